// >>> hw/ppoc_pkg.sv
// Constants and carrier types for the printer panel and on-line control.
// Assumes a single 40 MHz system clock; all slow timing runs off a 1 ms tick.
package ppoc_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_PERIOD_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;
    localparam int DEBOUNCE_MS = 10;
    localparam int SETTLE_MS = 2 * DEBOUNCE_MS;
    localparam int BELL_MS = 1000;
    localparam int LINE_REPEAT_MS = 100;
    localparam int MS_W = 11;
    localparam logic [7:0] BELL_CODE = 8'h07;
    localparam int PITCH_W = 7;
    // Pitch in 1/72 inch units; 12/72 is one sixth of an inch
    localparam logic [PITCH_W-1:0] PITCH_DEFAULT = 7'h0c;

    typedef enum logic [1:0] {
        MODE_INIT,
        MODE_SELFTEST,
        MODE_ONLINE,
        MODE_OFFLINE
    } ppoc_mode_t;

    typedef struct packed {
        logic online;
        logic pageAdv;
        logic lineAdv;
    } ppoc_buttons_t;

    typedef struct packed {
        logic byteValid;
        logic [7:0] byteData;
        logic sensorOff;
        logic sensorOn;
        logic pitchLoad;
        logic [PITCH_W-1:0] pitchValue;
    } ppoc_host_t;

    typedef struct packed {
        logic sensorOffSw;
        logic autoFeedSw;
    } ppoc_straps_t;

    typedef struct packed {
        logic ready;
        logic online;
        logic paperLow;
        logic buzzer;
    } ppoc_lamps_t;

    typedef struct packed {
        logic errorN;
        logic paperEnd;
        logic busy;
        logic ackEnable;
    } ppoc_if_t;
endpackage : ppoc_pkg

// >>> hw/ppoc_top.sv
// Panel, on-line state, paper-end status and self-test entry of a printer controller.
// Assumes synchronous inputs on clk_sys; host bytes and escape commands come pre-decoded.
//
// Behaviour
// - After power-up with paper loaded, come up on-line.
// - Online button press goes off-line and darkens the on-line lamp.
// - Online button presses are ignored while printing.
// - Paper out or mechanical fault forces off-line.
// - Page and line buttons act only while off-line.
// - Each page press off-line advances to next top-of-form.
// - Top-of-form reference is taken at power-up and on INIT.
// - Held line button repeats advances at programmed pitch, default one sixth inch.
// - Manual line advance is blocked while printing.
// - Ready lamp when data accepted; on-line lamp while on-line.
// - Paper-low lamp lights when sensor reports paper nearly out.
// - Bell character sounds the buzzer for about one second.
// - Paper out: stop, ERROR low, PE high, BUSY high, no ACKNLG.
// - Line advance still works in paper-out; online press resumes after reload.
// - Power cycle or INIT leaves paper-out and clears pitch and settings.
// - Switch 1-6 at init or disable command turns off paper-end detection.
// - Line button held at power-up starts self-test.
// - Self-test refused while paper is out.
// - Loopback check: ACK tied to strobe, switch 2-3 fixes auto feed. No strobe loopback here; autoFeedFixed follows the switch sampled at init.
// - Enable command turns paper-end detection back on.
`timescale 1ns/1ps

module ppoc_debounce #(
    parameter int STABLE_MS = 10
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic tickMs,
    input wire logic rawIn,
    output logic level,
    output logic press
);
    import ppoc_pkg::*;

    logic sync1_q;
    logic sync2_q;
    logic [MS_W-1:0] stableMs_q;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= rawIn;
            sync2_q <= sync1_q;
        end
    end

    // Level accepted only after it has held steady for the full window
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stableMs_q <= '0;
            level <= 1'b0;
            press <= 1'b0;
        end else begin
            press <= 1'b0;
            if (sync2_q == level) begin
                stableMs_q <= '0;
            end else if (tickMs) begin
                if (stableMs_q == MS_W'(STABLE_MS - 1)) begin
                    stableMs_q <= '0;
                    level <= sync2_q;
                    press <= sync2_q;
                end else begin
                    stableMs_q <= stableMs_q + 1'b1;
                end
            end
        end
    end
endmodule : ppoc_debounce

module ppoc_top #(
    parameter int TICK_CYCLES = ppoc_pkg::TICK_CYCLES,
    parameter int DEBOUNCE_MS = ppoc_pkg::DEBOUNCE_MS,
    parameter int SETTLE_MS = ppoc_pkg::SETTLE_MS,
    parameter int BELL_MS = ppoc_pkg::BELL_MS,
    parameter int LINE_REPEAT_MS = ppoc_pkg::LINE_REPEAT_MS
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic initReq,
    input wire ppoc_pkg::ppoc_buttons_t buttonsRaw,
    input wire logic paperNearEnd,
    input wire logic mechFault,
    input wire logic printActive,
    input wire logic selfTestDone,
    input wire ppoc_pkg::ppoc_host_t host,
    input wire ppoc_pkg::ppoc_straps_t straps,
    output ppoc_pkg::ppoc_lamps_t lamps,
    output ppoc_pkg::ppoc_if_t ifStat,
    output logic pageAdvance,
    output logic lineAdvance,
    output logic [ppoc_pkg::PITCH_W-1:0] linePitch,
    output logic tofSet,
    output logic selfTestRun,
    output logic autoFeedFixed
);
    import ppoc_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES);

    logic [TW-1:0] tickCnt_q;
    logic tickMs;
    ppoc_buttons_t held;
    ppoc_buttons_t pressed;
    ppoc_mode_t modeQ;
    ppoc_mode_t modeD;
    logic powerUp_q;
    logic sensorEn_q;
    logic autoFeed_q;
    logic [MS_W-1:0] settleMs_q;
    logic [MS_W-1:0] buzzMs_q;
    logic [MS_W-1:0] repeatMs_q;
    logic paperOut;
    logic acceptOk;
    logic bellHit;
    logic lineAllowed;

    // 1 ms enable tick
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tickCnt_q <= '0;
        end else if (tickCnt_q == TW'(TICK_CYCLES - 1)) begin
            tickCnt_q <= '0;
        end else begin
            tickCnt_q <= tickCnt_q + 1'b1;
        end
    end
    assign tickMs = (tickCnt_q == TW'(TICK_CYCLES - 1));

    ppoc_debounce #(.STABLE_MS(DEBOUNCE_MS)) u_dbOnline (
        .clk_sys(clk_sys), .resetn(resetn), .tickMs(tickMs),
        .rawIn(buttonsRaw.online), .level(held.online), .press(pressed.online)
    );
    ppoc_debounce #(.STABLE_MS(DEBOUNCE_MS)) u_dbPage (
        .clk_sys(clk_sys), .resetn(resetn), .tickMs(tickMs),
        .rawIn(buttonsRaw.pageAdv), .level(held.pageAdv), .press(pressed.pageAdv)
    );
    ppoc_debounce #(.STABLE_MS(DEBOUNCE_MS)) u_dbLine (
        .clk_sys(clk_sys), .resetn(resetn), .tickMs(tickMs),
        .rawIn(buttonsRaw.lineAdv), .level(held.lineAdv), .press(pressed.lineAdv)
    );

    assign paperOut = sensorEn_q && paperNearEnd;
    assign acceptOk = (modeQ == MODE_ONLINE) && !paperOut && !mechFault;
    assign bellHit = host.byteValid && (host.byteData == BELL_CODE);
    // Off-line includes paper-out, so feed from the panel still works there
    assign lineAllowed = (modeQ == MODE_OFFLINE) && !printActive;

    // On-line state
    always_comb begin
        modeD = modeQ;
        unique case (modeQ)
            MODE_INIT: begin
                if (settleMs_q == MS_W'(SETTLE_MS)) begin
                    if (powerUp_q && held.lineAdv && !paperOut) begin
                        modeD = MODE_SELFTEST;
                    end else if (!paperOut && !mechFault) begin
                        modeD = MODE_ONLINE;
                    end else begin
                        modeD = MODE_OFFLINE;
                    end
                end
            end
            MODE_SELFTEST: begin
                if (paperOut || mechFault) begin
                    modeD = MODE_OFFLINE;
                end else if (selfTestDone) begin
                    modeD = MODE_ONLINE;
                end
            end
            MODE_ONLINE: begin
                if (paperOut || mechFault) begin
                    modeD = MODE_OFFLINE;
                end else if (pressed.online && !printActive) begin
                    modeD = MODE_OFFLINE;
                end
            end
            MODE_OFFLINE: begin
                if (pressed.online && !printActive && !paperOut && !mechFault) begin
                    modeD = MODE_ONLINE;
                end
            end
        endcase
        if (initReq) begin
            modeD = MODE_INIT;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            modeQ <= MODE_INIT;
        end else begin
            modeQ <= modeD;
        end
    end

    // Power-up marker and settle wait so the line button level is known
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            powerUp_q <= 1'b1;
            settleMs_q <= '0;
        end else begin
            if (initReq || modeQ != MODE_INIT) begin
                powerUp_q <= 1'b0;
            end
            if (modeQ != MODE_INIT || initReq) begin
                settleMs_q <= '0;
            end else if (tickMs && settleMs_q != MS_W'(SETTLE_MS)) begin
                settleMs_q <= settleMs_q + 1'b1;
            end
        end
    end

    // Switch sampling and paper-end detection enable
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sensorEn_q <= 1'b1;
            autoFeed_q <= 1'b0;
        end else if (modeQ == MODE_INIT) begin
            sensorEn_q <= !straps.sensorOffSw;
            autoFeed_q <= straps.autoFeedSw;
        end else if (host.sensorOn) begin
            sensorEn_q <= 1'b1;
        end else if (host.sensorOff) begin
            sensorEn_q <= 1'b0;
        end
    end

    // Line pitch, reset to default on every initialisation
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            linePitch <= PITCH_DEFAULT;
        end else if (modeQ == MODE_INIT) begin
            linePitch <= PITCH_DEFAULT;
        end else if (host.pitchLoad) begin
            linePitch <= host.pitchValue;
        end
    end

    // Paper motion requests
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pageAdvance <= 1'b0;
            lineAdvance <= 1'b0;
            repeatMs_q <= '0;
            tofSet <= 1'b0;
        end else begin
            pageAdvance <= pressed.pageAdv && (modeQ == MODE_OFFLINE);
            tofSet <= (modeQ == MODE_INIT) && (modeD != MODE_INIT);
            lineAdvance <= 1'b0;
            if (!lineAllowed || !held.lineAdv) begin
                repeatMs_q <= '0;
            end else if (pressed.lineAdv) begin
                lineAdvance <= 1'b1;
                repeatMs_q <= '0;
            end else if (tickMs) begin
                if (repeatMs_q == MS_W'(LINE_REPEAT_MS - 1)) begin
                    lineAdvance <= 1'b1;
                    repeatMs_q <= '0;
                end else begin
                    repeatMs_q <= repeatMs_q + 1'b1;
                end
            end
        end
    end

    // Bell buzzer timer
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            buzzMs_q <= '0;
        end else if (bellHit) begin
            buzzMs_q <= MS_W'(BELL_MS);
        end else if (tickMs && buzzMs_q != '0) begin
            buzzMs_q <= buzzMs_q - 1'b1;
        end
    end

    // Lamps and interface status lines
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lamps <= '0;
            ifStat <= '{errorN: 1'b1, paperEnd: 1'b0, busy: 1'b1, ackEnable: 1'b0};
            selfTestRun <= 1'b0;
            autoFeedFixed <= 1'b0;
        end else begin
            lamps.ready <= acceptOk;
            lamps.online <= (modeQ == MODE_ONLINE);
            lamps.paperLow <= paperOut;
            lamps.buzzer <= bellHit || (buzzMs_q != '0);
            ifStat.errorN <= !(paperOut || mechFault);
            ifStat.paperEnd <= paperOut;
            ifStat.busy <= !acceptOk || printActive;
            ifStat.ackEnable <= acceptOk;
            selfTestRun <= (modeQ == MODE_SELFTEST);
            autoFeedFixed <= autoFeed_q;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    sequence s_offPress;
        (modeQ == MODE_ONLINE) && pressed.online && !printActive && !paperOut
            && !mechFault && !initReq;
    endsequence
    sequence s_goneOffline;
        (modeQ == MODE_OFFLINE) ##1 !lamps.online;
    endsequence
    property p_press_offline;
        s_offPress |=> s_goneOffline;
    endproperty
    a_press_offline: assert property (p_press_offline)
        else $error("online press did not go off-line");
    property p_ignore_printing;
        (modeQ == MODE_ONLINE) && pressed.online && printActive && !paperOut
            && !mechFault && !initReq |=> modeQ == MODE_ONLINE;
    endproperty
    a_ignore_printing: assert property (p_ignore_printing)
        else $error("online press acted while printing");
    property p_auto_offline;
        (modeQ == MODE_ONLINE) && (paperOut || mechFault) && !initReq |=> modeQ == MODE_OFFLINE;
    endproperty
    a_auto_offline: assert property (p_auto_offline)
        else $error("fault did not force off-line");
    property p_page_offline_only;
        modeQ != MODE_OFFLINE |=> !pageAdvance;
    endproperty
    a_page_offline_only: assert property (p_page_offline_only)
        else $error("page advance while not off-line");
    property p_line_blocked;
        printActive |=> !lineAdvance;
    endproperty
    a_line_blocked: assert property (p_line_blocked)
        else $error("line advance while printing");
    property p_online_lamp;
        modeQ == MODE_ONLINE |=> lamps.online && (lamps.ready == $past(acceptOk));
    endproperty
    a_online_lamp: assert property (p_online_lamp)
        else $error("on-line or ready lamp wrong");
    property p_paper_out_status;
        paperOut |=> lamps.paperLow && ifStat.paperEnd && !ifStat.errorN && ifStat.busy
            && !ifStat.ackEnable;
    endproperty
    a_paper_out_status: assert property (p_paper_out_status)
        else $error("paper-out status lines wrong");
    property p_bell_buzz;
        bellHit |=> lamps.buzzer [*8];
    endproperty
    a_bell_buzz: assert property (p_bell_buzz)
        else $error("buzzer did not sound on bell");
    property p_sensor_cmd;
        (modeQ != MODE_INIT) && host.sensorOff && !host.sensorOn |=> !sensorEn_q && !paperOut;
    endproperty
    a_sensor_cmd: assert property (p_sensor_cmd)
        else $error("disable command kept detection on");
    property p_pitch_init;
        modeQ == MODE_INIT |=> linePitch == PITCH_DEFAULT;
    endproperty
    a_pitch_init: assert property (p_pitch_init)
        else $error("pitch not reset on init");
endmodule : ppoc_top

// >>> testbench/ppoc_host_model.sv
// Host model: offers bytes and decoded escape commands to the panel logic.
// Assumes the bench calls its tasks at falling edges; busy comes from the device.
`timescale 1ns/1ps

module ppoc_host_model (
    input wire logic clk_sys,
    input wire logic busy,
    output ppoc_pkg::ppoc_host_t host
);
    import ppoc_pkg::*;

    initial begin
        host = '0;
    end

    // Byte offered once the printer is not busy, or after 200 cycles of waiting
    task automatic send_byte(input logic [7:0] value);
        int guard;
        guard = 0;
        while (busy !== 1'b0 && guard < 200) begin
            @(negedge clk_sys);
            guard++;
        end
        host.byteData = value;
        host.byteValid = 1'b1;
        @(negedge clk_sys);
        host.byteValid = 1'b0;
        // Stale data lines never repeat the last byte
        host.byteData = ~value;
    endtask : send_byte

    // Kind 0 detection off, 1 detection on, 2 pitch load
    task automatic send_cmd(input int kind, input logic [PITCH_W-1:0] pitch);
        host.sensorOff = (kind == 0);
        host.sensorOn = (kind == 1);
        host.pitchLoad = (kind == 2);
        host.pitchValue = pitch;
        @(negedge clk_sys);
        host.sensorOff = 1'b0;
        host.sensorOn = 1'b0;
        host.pitchLoad = 1'b0;
        host.pitchValue = ~pitch;
    endtask : send_cmd
endmodule : ppoc_host_model

// >>> testbench/ppoc_top_test.sv
// Self-checking bench for the printer panel and on-line control.
// Assumes shortened timing: one ms tick is four clock cycles.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmpCount++; if ((got) !== (ex)) begin badCount++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module ppoc_top_test;
    import ppoc_pkg::*;
    localparam logic [2:0] N_PAGE = 3'h4;
    localparam logic [2:0] N_LINE = 3'h2;
    localparam logic [2:0] N_TOF = 3'h1;
    localparam int B_ON = 2;
    localparam int B_PG = 1;
    localparam int B_LN = 0;
    logic clk_sys = 1'b0;
    logic resetn;
    logic initReq;
    ppoc_buttons_t buttonsRaw;
    logic paperNearEnd;
    logic mechFault;
    logic printActive;
    logic selfTestDone;
    ppoc_host_t host;
    ppoc_straps_t straps;
    ppoc_lamps_t lamps;
    ppoc_if_t ifStat;
    logic pageAdvance;
    logic lineAdvance;
    logic [PITCH_W-1:0] linePitch;
    logic tofSet;
    logic selfTestRun;
    logic autoFeedFixed;
    logic [2:0] noteQ[$];
    logic [2:0] expNote;
    logic [31:0] rng = 32'h2;
    logic [PITCH_W-1:0] pv;
    int badCount = 0;
    int cmpCount = 0;
    int cycles = 0;

    always #12.5 clk_sys = ~clk_sys;

    ppoc_top #(.TICK_CYCLES(4), .DEBOUNCE_MS(2), .SETTLE_MS(4), .BELL_MS(8),
        .LINE_REPEAT_MS(8)) i_ppoc_top (.clk_sys, .resetn, .initReq, .buttonsRaw,
        .paperNearEnd, .mechFault, .printActive, .selfTestDone, .host, .straps, .lamps,
        .ifStat, .pageAdvance, .lineAdvance, .linePitch, .tofSet, .selfTestRun,
        .autoFeedFixed);

    ppoc_host_model i_ppoc_host_model (.clk_sys, .busy(ifStat.busy), .host);

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xorshift

    task automatic wrap_up();
        if (noteQ.size() != 0) begin
            badCount++;
            $display("MISMATCH pulses expected %0d seen 0", noteQ.size());
        end
        $display("Checks %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    // Pulse watcher: each pulse takes the oldest note
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 4000) begin
            badCount++;
            wrap_up();
        end
        if (resetn && (pageAdvance || lineAdvance || tofSet) === 1'b1) begin
            expNote = noteQ.size() > 0 ? noteQ.pop_front() : 3'h0;
            `CHK("pulse", expNote, {pageAdvance, lineAdvance, tofSet})
        end
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick

    task automatic press(input int b);
        buttonsRaw[b] = 1'b1;
        tick(24);
        buttonsRaw[b] = 1'b0;
        tick(24);
    endtask : press

    task automatic do_reset(input logic held);
        resetn = 1'b0;
        buttonsRaw.lineAdv = held;
        tick(16);
        `CHK("lamps", 4'h0, lamps)
        `CHK("ifStat", 4'ha, ifStat)
        `CHK("pitch", 7'h0c, linePitch)
        noteQ.push_back(N_TOF);
        resetn = 1'b1;
        tick(24);
        buttonsRaw.lineAdv = 1'b0;
        tick(30);
    endtask : do_reset

    task automatic do_init();
        noteQ.push_back(N_TOF);
        initReq = 1'b1;
        tick(1);
        initReq = 1'b0;
        tick(40);
    endtask : do_init

    initial begin
        resetn = 1'b0;
        initReq = 1'b0;
        buttonsRaw = '0;
        paperNearEnd = 1'b0;
        mechFault = 1'b0;
        printActive = 1'b0;
        selfTestDone = 1'b0;
        straps = '0;
        do_reset(1'b0);
        `CHK("lamps", 4'hc, lamps)
        // Panel motion refused while on-line
        press(B_PG);
        press(B_LN);
        printActive = 1'b1;
        press(B_ON);
        `CHK("online", 1'b1, lamps.online)
        `CHK("busy", 1'b1, ifStat.busy)
        printActive = 1'b0;
        press(B_ON);
        `CHK("lamps", 4'h0, lamps)
        noteQ.push_back(N_PAGE);
        press(B_PG);
        printActive = 1'b1;
        press(B_LN);
        printActive = 1'b0;
        rng = xorshift(rng);
        pv = rng[6:0];
        i_ppoc_host_model.send_cmd(2, pv);
        tick(2);
        `CHK("pitch", pv, linePitch)
        // Held button: two advances, then let go
        noteQ.push_back(N_LINE);
        noteQ.push_back(N_LINE);
        buttonsRaw.lineAdv = 1'b1;
        for (int i = 0; i < 200 && noteQ.size() > 0; i++) begin
            tick(1);
        end
        buttonsRaw.lineAdv = 1'b0;
        tick(40);
        `CHK("notes", 0, noteQ.size())
        do_init();
        `CHK("pitch", 7'h0c, linePitch)
        `CHK("online", 1'b1, lamps.online)
        paperNearEnd = 1'b1;
        tick(4);
        `CHK("lamps", 4'h2, lamps)
        `CHK("ifStat", 4'h6, ifStat)
        noteQ.push_back(N_LINE);
        press(B_LN);
        paperNearEnd = 1'b0;
        press(B_ON);
        `CHK("online", 1'b1, lamps.online)
        mechFault = 1'b1;
        tick(4);
        `CHK("online", 1'b0, lamps.online)
        mechFault = 1'b0;
        press(B_ON);
        i_ppoc_host_model.send_cmd(0, 7'h00);
        paperNearEnd = 1'b1;
        tick(4);
        `CHK("pe", 1'b0, ifStat.paperEnd)
        `CHK("online", 1'b1, lamps.online)
        i_ppoc_host_model.send_cmd(1, 7'h00);
        tick(4);
        `CHK("pe", 1'b1, ifStat.paperEnd)
        paperNearEnd = 1'b0;
        press(B_ON);
        // Switch moved while running waits for the next init
        straps.sensorOffSw = 1'b1;
        paperNearEnd = 1'b1;
        tick(4);
        `CHK("pe", 1'b1, ifStat.paperEnd)
        paperNearEnd = 1'b0;
        do_init();
        paperNearEnd = 1'b1;
        tick(4);
        `CHK("pe", 1'b0, ifStat.paperEnd)
        paperNearEnd = 1'b0;
        straps.sensorOffSw = 1'b0;
        rng = xorshift(rng);
        i_ppoc_host_model.send_byte(rng[7:0] | 8'h10);
        tick(2);
        `CHK("buzz", 1'b0, lamps.buzzer)
        i_ppoc_host_model.send_byte(BELL_CODE);
        tick(24);
        `CHK("buzz", 1'b1, lamps.buzzer)
        tick(18);
        `CHK("buzz", 1'b0, lamps.buzzer)
        straps.autoFeedSw = 1'b1;
        do_reset(1'b1);
        `CHK("selftest", 1'b1, selfTestRun)
        `CHK("autofeed", 1'b1, autoFeedFixed)
        selfTestDone = 1'b1;
        tick(1);
        selfTestDone = 1'b0;
        tick(4);
        `CHK("online", 1'b1, lamps.online)
        paperNearEnd = 1'b1;
        do_reset(1'b1);
        `CHK("selftest", 1'b0, selfTestRun)
        paperNearEnd = 1'b0;
        do_init();
        `CHK("online", 1'b1, lamps.online)
        wrap_up();
    end
endmodule : ppoc_top_test
